/* File: hw/inclusive_or_instruction_unit.sv */
// Inclusive-OR instruction decode and execute unit with APB registers
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "or_unit_consts.svh"

// What this block does
// - Decode literal OR from upper byte 09
// - Literal OR result goes to accumulator
// - Only negative and zero flags update
// - Decode file OR from upper bits 000100
// - Destination bit picks accumulator or file
// - Bank bit picks access bank or bank
// - Extended mode indexes offsets up to 5Fh when the bank bit is clear
module inclusive_or_instruction_unit
   import or_unit_pkg::*;
(
   input wire logic CLK_IN,
   input wire logic SYS_RST_IN,
   input wire logic [15:0] INSTR_IN,
   input wire logic INSTR_VALID_IN,
   output logic INSTR_READY_OUT,
   output logic DONE_OUT,
   output logic [11:0] FILE_ADDR_OUT,
   output logic [7:0] FILE_WDATA_OUT,
   output logic FILE_RE_OUT,
   output logic FILE_WE_OUT,
   input wire logic [7:0] FILE_RDATA_IN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR
);

   // ==========================================================
   // Helper functions
   // ==========================================================

   // Effective data address of a file-register operand
   function automatic logic [11:0] file_address(
      input logic [7:0] f,
      input logic banked,
      input logic ext,
      input logic [3:0] bank,
      input logic [11:0] base
   );
      logic [11:0] addr;
      addr = {4'h0, f};
      if (banked)
      begin
         // Bank register supplies the upper bits
         addr = {bank, f};
      end
      else if (ext && (f <= `ORU_INDEX_MAX))
      begin
         // Indexed literal offset from the index base
         addr = base + {4'h0, f};
      end
      else if (f >= `ORU_ACCESS_SPLIT)
      begin
         // Upper part of the access bank is the special area
         addr = {`ORU_ACCESS_HIGH, f};
      end
      return addr;
   endfunction

   // Status with only negative and zero replaced
   function automatic logic [4:0] flag_update(
      input logic [4:0] old,
      input logic [7:0] res
   );
      logic [4:0] s;
      s = old;
      s[`ORU_ZERO_BIT] = (res == 8'h00);
      s[`ORU_NEG_BIT] = res[7];
      return s;
   endfunction

   // ==========================================================
   // State
   // ==========================================================

   unit_state_t cur; // Registered state
   unit_state_t next_cur; // Next value of the state
   logic apb_commit; // Access phase completes at this edge
   logic apb_start; // Access phase seen, answer next cycle
   logic idle; // No instruction in flight

   // ==========================================================
   // Next-state logic
   // ==========================================================

   // Instruction phases and APB slave in one process
   always_comb
   begin
      next_cur = cur;
      next_cur.done = 1'b0;
      idle = (cur.phase == PH_IDLE);
      apb_commit = PSEL && PENABLE && cur.apb.ready;
      apb_start = PSEL && PENABLE && !cur.apb.ready;

      case (cur.phase)
         PH_IDLE:
         begin
            // Take a word while ready and offered
            if (INSTR_VALID_IN && cur.instr_ready)
            begin
               next_cur.instr = INSTR_IN;
               next_cur.instr_ready = 1'b0;
               next_cur.phase = PH_Q1;
            end
         end
         PH_Q1:
         begin
            next_cur.is_lit = (cur.instr[15:8] == `ORU_OP_LIT);
            next_cur.is_file = (cur.instr[15:10] == `ORU_OP_FILE);
            next_cur.unsupported = !((cur.instr[15:8] == `ORU_OP_LIT) ||
               (cur.instr[15:10] == `ORU_OP_FILE));
            next_cur.file.addr = file_address(cur.instr[7:0],
               cur.instr[8], cur.ext_en, cur.bank, cur.index_base);
            next_cur.file.re = (cur.instr[15:10] == `ORU_OP_FILE);
            next_cur.phase = PH_Q2;
         end
         PH_Q2:
         begin
            if (cur.is_file)
            begin
               next_cur.operand = FILE_RDATA_IN;
            end
            else
            begin
               next_cur.operand = cur.instr[7:0];
            end
            next_cur.file.re = 1'b0;
            next_cur.phase = PH_Q3;
         end
         PH_Q3:
         begin
            next_cur.result = cur.acc | cur.operand;
            next_cur.file.wdata = cur.acc | cur.operand;
            // destination bit set writes the file
            next_cur.file.we = cur.is_file && cur.instr[9];
            next_cur.phase = PH_Q4;
         end
         PH_Q4:
         begin
            if (cur.is_lit || (cur.is_file && !cur.instr[9]))
            begin
               next_cur.acc = cur.result;
            end
            if (!cur.unsupported)
            begin
               next_cur.status = flag_update(cur.status, cur.result);
            end
            next_cur.file.we = 1'b0;
            next_cur.done = 1'b1;
            next_cur.instr_ready = 1'b1;
            next_cur.phase = PH_IDLE;
         end
         default:
         begin
            // Unknown code recovers to idle
            next_cur.phase = PH_IDLE;
            next_cur.instr_ready = 1'b1;
         end
      endcase

      // APB: one wait state, answer registered
      next_cur.apb.ready = apb_start;
      if (apb_start)
      begin
         next_cur.apb.slverr = 1'b0;
         next_cur.apb.rdata = 32'h0000_0000;
         if (PADDR == `ORU_REG_CTRL)
         begin
            next_cur.apb.rdata = {31'h0000_0000, cur.ext_en};
         end
         else if (PADDR == `ORU_REG_ACC)
         begin
            next_cur.apb.rdata = {24'h00_0000, cur.acc};
         end
         else if (PADDR == `ORU_REG_STATUS)
         begin
            next_cur.apb.rdata = {27'h000_0000, cur.status};
         end
         else if (PADDR == `ORU_REG_BANK)
         begin
            next_cur.apb.rdata = {28'h000_0000, cur.bank};
         end
         else if (PADDR == `ORU_REG_INDEX)
         begin
            next_cur.apb.rdata = {20'h0_0000, cur.index_base};
         end
         else if (PADDR == `ORU_REG_STATE)
         begin
            next_cur.apb.rdata = {26'h000_0000, cur.unsupported,
               cur.phase};
         end
         else
         begin
            // Unmapped address answers with an error
            next_cur.apb.slverr = 1'b1;
         end
      end

      // Writes land only while idle, so a running op is never torn
      if (apb_commit && PWRITE && idle)
      begin
         if (PADDR == `ORU_REG_CTRL)
         begin
            next_cur.ext_en = PWDATA[0];
         end
         else if (PADDR == `ORU_REG_ACC)
         begin
            next_cur.acc = PWDATA[7:0];
         end
         else if (PADDR == `ORU_REG_STATUS)
         begin
            next_cur.status = PWDATA[4:0];
         end
         else if (PADDR == `ORU_REG_BANK)
         begin
            next_cur.bank = PWDATA[3:0];
         end
         else if (PADDR == `ORU_REG_INDEX)
         begin
            next_cur.index_base = PWDATA[11:0];
         end
      end
   end

   // ==========================================================
   // State register
   // ==========================================================

   // Synchronous reset to constants only
   always_ff @(posedge CLK_IN)
   begin
      if (SYS_RST_IN)
      begin
         cur <= '0;
         cur.phase <= PH_IDLE;
         cur.acc <= `ORU_ACC_RST;
         cur.status <= `ORU_STATUS_RST;
         cur.bank <= `ORU_BANK_RST;
         cur.index_base <= `ORU_INDEX_RST;
         cur.instr_ready <= 1'b1;
      end
      else
      begin
         cur <= next_cur;
      end
   end

   // ==========================================================
   // Outputs, all straight from the state flops
   // ==========================================================

   assign INSTR_READY_OUT = cur.instr_ready;
   assign DONE_OUT = cur.done;
   assign FILE_ADDR_OUT = cur.file.addr;
   assign FILE_WDATA_OUT = cur.file.wdata;
   assign FILE_RE_OUT = cur.file.re;
   assign FILE_WE_OUT = cur.file.we;
   assign PRDATA = cur.apb.rdata;
   assign PREADY = cur.apb.ready;
   assign PSLVERR = cur.apb.slverr;

endmodule
`default_nettype wire

/* File: hw/or_unit_consts.svh */
// Constants for the inclusive-OR instruction unit
`ifndef OR_UNIT_CONSTS_SVH
`define OR_UNIT_CONSTS_SVH

// APB register byte offsets
`define ORU_REG_CTRL 12'h000
`define ORU_REG_ACC 12'h004
`define ORU_REG_STATUS 12'h008
`define ORU_REG_BANK 12'h00C
`define ORU_REG_INDEX 12'h010
`define ORU_REG_STATE 12'h014

// Status register field positions
`define ORU_ZERO_BIT 2
`define ORU_NEG_BIT 4
`define ORU_STATUS_W 5

// Reset values
`define ORU_ACC_RST 8'h00
`define ORU_STATUS_RST 5'h00
`define ORU_BANK_RST 4'h0
`define ORU_INDEX_RST 12'h000

// Opcode patterns
`define ORU_OP_LIT 8'h09
`define ORU_OP_FILE 6'h04

// Access bank split and upper access bank base
`define ORU_ACCESS_SPLIT 8'h60
`define ORU_ACCESS_HIGH 4'hF
`define ORU_INDEX_MAX 8'h5F

`endif

/* File: hw/or_unit_pkg.sv */
// Types for the inclusive-OR instruction unit
package or_unit_pkg;

   // One-hot instruction phases
   typedef enum logic [4:0]
   {
      PH_IDLE = 5'h01,
      PH_Q1 = 5'h02,
      PH_Q2 = 5'h04,
      PH_Q3 = 5'h08,
      PH_Q4 = 5'h10
   } phase_t;

   // Data memory request carried as one group
   typedef struct packed
   {
      logic [11:0] addr;
      logic [7:0] wdata;
      logic re;
      logic we;
   } file_req_t;

   // APB answer group
   typedef struct packed
   {
      logic [31:0] rdata;
      logic ready;
      logic slverr;
   } apb_rsp_t;

   // Whole state of the unit
   typedef struct packed
   {
      phase_t phase;
      logic [15:0] instr;
      logic [7:0] acc;
      logic [4:0] status;
      logic [3:0] bank;
      logic [11:0] index_base;
      logic ext_en;
      logic is_lit;
      logic is_file;
      logic [7:0] operand;
      logic [7:0] result;
      logic unsupported;
      logic instr_ready;
      logic done;
      file_req_t file;
      apb_rsp_t apb;
   } unit_state_t;

endpackage

/* File: tb/file_mem.sv */
// Data memory model that answers the unit's file port
`timescale 1ns/10ps
`default_nettype none
module file_mem
(
   input wire logic clk,
   input wire logic [11:0] addr,
   input wire logic re,
   input wire logic we,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata
);
   // Backing store for the whole 4K data space
   logic [7:0] mem [4096];
   // Outside a read the bus shows the inverse, so a late sample shows up
   assign rdata = re ? mem[addr] : ~mem[addr];
   // The write strobe stores the result
   always @(posedge clk)
      if (we)
         mem[addr] <= wdata;
endmodule
`default_nettype wire

/* File: tb/or_unit_chk.sv */
// Port timing checks for the inclusive-OR unit
`timescale 1ns/10ps
`default_nettype none
module or_unit_chk
(
   input wire logic CLK_IN,
   input wire logic SYS_RST_IN,
   input wire logic [15:0] INSTR_IN,
   input wire logic INSTR_VALID_IN,
   input wire logic INSTR_READY_OUT,
   input wire logic DONE_OUT,
   input wire logic [11:0] FILE_ADDR_OUT,
   input wire logic FILE_RE_OUT,
   input wire logic FILE_WE_OUT,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PREADY
);
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (SYS_RST_IN);
   // Word taken at this edge
   wire logic take = INSTR_VALID_IN && INSTR_READY_OUT;
   // ==========================================================
   // Instruction slot
   busy_ready_a: assert property (take |=>
      !INSTR_READY_OUT [*4] ##1 (INSTR_READY_OUT && DONE_OUT))
      else $error("ready or done outside the five cycle slot");
   done_pulse_a: assert property (DONE_OUT |=> !DONE_OUT)
      else $error("done longer than one cycle");
   write_done_a: assert property (FILE_WE_OUT |=> DONE_OUT)
      else $error("write strobe not in the last phase");
   read_slot_a: assert property (take |-> ##2
      (FILE_RE_OUT == ($past(INSTR_IN[15:10], 2) == 6'h04)))
      else $error("file read not tied to the file opcode");
   write_slot_a: assert property (take |-> ##4
      (FILE_WE_OUT == ($past(INSTR_IN[15:9], 4) == 7'h09)))
      else $error("file write not tied to destination bit");
   access_high_a: assert property (take &&
      {INSTR_IN[15:10], INSTR_IN[8]} == 7'h08 && INSTR_IN[7:0] >= 8'h60
      |-> ##2 FILE_ADDR_OUT == {4'hF, $past(INSTR_IN[7:0], 2)})
      else $error("upper access bank address wrong");
   // ==========================================================
   // Register bus
   apb_wait_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
      else $error("register access answer late");
   apb_pulse_a: assert property (PREADY |=> !PREADY)
      else $error("ready held over two cycles");
endmodule
bind inclusive_or_instruction_unit or_unit_chk u_or_unit_chk
(
   .CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN), .INSTR_IN(INSTR_IN),
   .INSTR_VALID_IN(INSTR_VALID_IN), .INSTR_READY_OUT(INSTR_READY_OUT),
   .DONE_OUT(DONE_OUT), .FILE_ADDR_OUT(FILE_ADDR_OUT),
   .FILE_RE_OUT(FILE_RE_OUT), .FILE_WE_OUT(FILE_WE_OUT),
   .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY)
);
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the inclusive-OR unit
`timescale 1ns/10ps
`default_nettype none
`include "or_unit_consts.svh"
module tb_top;
   logic CLK_IN = 1'b0, SYS_RST_IN = 1'b1, INSTR_VALID_IN = 1'b0;
   logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
   logic [15:0] INSTR_IN = 16'h0000;
   logic [11:0] PADDR = 12'h000;
   logic [31:0] PWDATA = 32'h00000000, PRDATA, r;
   logic INSTR_READY_OUT, DONE_OUT, FILE_RE_OUT, FILE_WE_OUT;
   logic PREADY, PSLVERR, err;
   logic [11:0] FILE_ADDR_OUT;
   logic [7:0] FILE_WDATA_OUT, FILE_RDATA_IN;
   int mismatches = 0, comparisons = 0;
   inclusive_or_instruction_unit u_inclusive_or_instruction_unit
   (
      .CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN), .INSTR_IN(INSTR_IN),
      .INSTR_VALID_IN(INSTR_VALID_IN), .INSTR_READY_OUT(INSTR_READY_OUT),
      .DONE_OUT(DONE_OUT), .FILE_ADDR_OUT(FILE_ADDR_OUT),
      .FILE_WDATA_OUT(FILE_WDATA_OUT), .FILE_RE_OUT(FILE_RE_OUT),
      .FILE_WE_OUT(FILE_WE_OUT), .FILE_RDATA_IN(FILE_RDATA_IN),
      .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
      .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR)
   );
   file_mem u_file_mem
   (
      .clk(CLK_IN), .addr(FILE_ADDR_OUT), .re(FILE_RE_OUT),
      .we(FILE_WE_OUT), .wdata(FILE_WDATA_OUT), .rdata(FILE_RDATA_IN)
   );
   // ==========================================================
   // Clock, 40 ns period
   initial
      forever #20 CLK_IN = ~CLK_IN;
   // One counted compare
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One bus transfer; an edge first so no signal is set twice at once
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge CLK_IN);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK_IN);
      PENABLE <= 1'b1;
      do @(posedge CLK_IN); while (PREADY !== 1'b1 && n++ < 40);
      // A wait that ran out of its limit counts as a mismatch
      chk({31'h0, (n > 40)}, 32'h0);
      r = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h00000000);
      chk(r, exp);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   // Offer one word, then wait for its completion pulse
   task automatic exec(input logic [15:0] w);
      int n;
      n = 0;
      @(posedge CLK_IN);
      INSTR_IN <= w;
      INSTR_VALID_IN <= 1'b1;
      do @(posedge CLK_IN); while (INSTR_READY_OUT !== 1'b1 && n++ < 40);
      INSTR_VALID_IN <= 1'b0;
      do @(posedge CLK_IN); while (DONE_OUT !== 1'b1 && n++ < 40);
      // A word that never finished counts as a mismatch
      chk({31'h0, (n > 40)}, 32'h0);
   endtask
   // ==========================================================
   // Scenarios
   task automatic test_lit();
      rd(`ORU_REG_STATE, 32'h01);
      wr(`ORU_REG_STATUS, 32'h0B);
      wr(`ORU_REG_ACC, 32'h9A);
      exec(16'h0935);
      rd(`ORU_REG_ACC, 32'hBF);
      rd(`ORU_REG_STATUS, 32'h1B);
      wr(`ORU_REG_ACC, 32'h00);
      exec(16'h0900);
      rd(`ORU_REG_STATUS, 32'h0F);
      $display("literal test done");
   endtask
   // Banked read with result to accumulator, then upper page write-back
   task automatic test_file();
      u_file_mem.mem[12'h312] = 8'h91;
      u_file_mem.mem[12'hF80] = 8'h40;
      wr(`ORU_REG_BANK, 32'h3);
      wr(`ORU_REG_ACC, 32'h13);
      exec(16'h1112);
      rd(`ORU_REG_ACC, 32'h93);
      chk(u_file_mem.mem[12'h312], 32'h91);
      wr(`ORU_REG_ACC, 32'h02);
      exec(16'h1280);
      chk(u_file_mem.mem[12'hF80], 32'h42);
      rd(`ORU_REG_ACC, 32'h02);
      rd(`ORU_REG_STATUS, 32'h0B);
      $display("file test done");
   endtask
   // Offset 5F reads 55 directly, then base 200 plus 5F once extended
   task automatic test_index();
      u_file_mem.mem[12'h25F] = 8'h00;
      u_file_mem.mem[12'h05F] = 8'h55;
      wr(`ORU_REG_INDEX, 32'h200);
      wr(`ORU_REG_ACC, 32'h00);
      exec(16'h105F);
      rd(`ORU_REG_ACC, 32'h55);
      rd(`ORU_REG_STATUS, 32'h0B);
      wr(`ORU_REG_CTRL, 32'h1);
      wr(`ORU_REG_ACC, 32'h00);
      exec(16'h105F);
      rd(`ORU_REG_ACC, 32'h00);
      rd(`ORU_REG_STATUS, 32'h0F);
      $display("index test done");
   endtask
   // Unmapped address and a foreign opcode
   task automatic test_refuse();
      rd(12'h018, 32'h0);
      chk({31'h0, err}, 32'h1);
      exec(16'h0E55);
      rd(`ORU_REG_STATE, 32'h21);
      rd(`ORU_REG_ACC, 32'h00);
      $display("refuse test done");
   endtask
   // Mid-run reset brings state, accumulator, bank, control and status back to their reset values
   task automatic test_reset();
      wr(`ORU_REG_ACC, 32'h77);
      @(posedge CLK_IN);
      SYS_RST_IN <= 1'b1;
      repeat (2) @(posedge CLK_IN);
      SYS_RST_IN <= 1'b0;
      rd(`ORU_REG_STATE, 32'h01);
      rd(`ORU_REG_ACC, 32'h00);
      rd(`ORU_REG_BANK, 32'h0);
      rd(`ORU_REG_CTRL, 32'h0);
      rd(`ORU_REG_STATUS, 32'h0);
      $display("reset test done");
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Main sequence after eight reset cycles
   initial
   begin
      repeat (8) @(posedge CLK_IN);
      SYS_RST_IN <= 1'b0;
      test_lit();
      test_file();
      test_index();
      test_refuse();
      test_reset();
      results();
   end
   // Watchdog well past the expected few hundred cycles
   initial
   begin
      #80000;
      mismatches++;
      results();
   end
endmodule
`default_nettype wire
